// file: common/adtr_pkg.sv
// shared constants, types and decode helpers for the converter trigger block
package adtr_pkg;

   // ***********************************************************
   // register indices (byte address is four times the index)
   // ***********************************************************
   localparam logic [7:0] IDX_CTRL_A = 8'h7A;  // converter_control_a
   localparam logic [7:0] IDX_CTRL_B = 8'h7B;  // converter_control_b
   localparam logic [7:0] IDX_GATE = 8'h7E;    // analog_pin_input_gate

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int A_EN_BIT = 7;     // converter_enable
   localparam int A_START_BIT = 6;  // start / busy
   localparam int A_ATE_BIT = 5;    // auto_trigger_enable
   localparam int A_DONE_BIT = 4;   // conversion_done_flag
   localparam int B_COMPARATOR_MUX_ENABLE_BIT = 6;   // comparator_mux_enable
   localparam int B_TS_LSB = 0;     // trigger_source_select low bit
   localparam int TS_W = 3;         // trigger_source_select width
   localparam int GATE_W = 6;       // analog_pin_input_disable bits

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [7:0] RST_CTRL_A = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_GATE = 8'h00;

   // writable masks, everything else reads zero
   localparam logic [7:0] MASK_CTRL_B = 8'h47;
   localparam logic [7:0] MASK_GATE = 8'h3F;

   // trigger source codes
   typedef enum logic [TS_W-1:0] {
      TS_FREE_RUN,      // conversion_done_flag
      TS_COMPARATOR,    // analog comparator flag
      TS_EXT_INT0,      // external interrupt request zero
      TS_T0_CMP_A,      // 8-bit timer compare match A
      TS_T0_OVF,        // 8-bit timer overflow
      TS_T1_CMP_B,      // 16-bit timer compare match B
      TS_T1_OVF,        // 16-bit timer overflow
      TS_T1_CAPT        // 16-bit timer input capture
   } adtr_src_t;

   // pick the selected flag; bit 0 of flags is the done flag
   function automatic logic adtr_pick(input logic [7:0] flags, input logic [TS_W-1:0] sel);
      adtr_pick = flags[sel];
   endfunction

   // byte address of a register index
   function automatic logic [9:0] adtr_addr(input logic [7:0] idx);
      adtr_addr = {idx, 2'b00};
   endfunction

endpackage

// file: core/adtr_trig_edge.sv
// trigger source selection and rising-edge detection
`timescale 1ns/1ps
module adtr_trig_edge import adtr_pkg::*; #(
   parameter int SEL_W = TS_W
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [(1<<SEL_W)-1:0] flags_in,  // bit 0 is the done flag
   input wire logic [SEL_W-1:0] sel_in,
   output logic level_out,   // selected flag now
   output logic edge_out     // one-cycle rising edge
);

   // ***********************************************************
   // elaboration check
   // ***********************************************************
   if (SEL_W != TS_W) begin : g_bad_w
      $error("adtr_trig_edge: SEL_W must equal TS_W");
   end

   logic prev_level_q;          // previous sample of the selected flag
   logic [SEL_W-1:0] prev_sel_q; // previous selection
   logic to_free;               // selection just moved to free running

   // current selected level, source change included
   assign level_out = adtr_pick(flags_in, sel_in);

   // moving onto free running never counts as an edge
   assign to_free = (sel_in == TS_FREE_RUN) && (prev_sel_q != TS_FREE_RUN);

   // compare with last sample, so a source switch acts as any edge
   assign edge_out = ce_in && level_out && !prev_level_q && !to_free;

   // sample once per enabled clock
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         prev_level_q <= 1'b0;
         prev_sel_q <= '0;
      end else if (ce_in) begin
         prev_level_q <= level_out;
         prev_sel_q <= sel_in;
      end
   end

endmodule // adtr_trig_edge

// file: core/adtr_trig_ctrl.sv
// converter trigger, comparator input steering and analog pin gating
//
// Behaviour
// - mux to comparator when enabled bit, converter off
// - otherwise dedicated negative pin feeds comparator
// - source field acts only with auto-trigger
// - conversion starts on selected flag rising edge
// - switching from a clear to a set source makes an edge
// - switching to free running never triggers
// - codes 000 free, 001 comparator, 010 int0
// - codes 011 timer0 match A, 100 overflow
// - codes 101 match B, 110 overflow, 111 capture
// - disable bit switches pin input buffer off
// - disabled pin reads zero in port input
// - enable turns on; clearing aborts conversion
// - auto-trigger arms start on trigger edge
// - done flag sets when conversion finishes
`timescale 1ns/1ps
module adtr_trig_ctrl import adtr_pkg::*; #(
   parameter int ADDR_W = 12,
   parameter int PINS = GATE_W
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // event flags of the trigger sources, codes 1..7
   input wire logic [7:1] src_flags_in,
   // conversion engine
   input wire logic conv_done_in,
   output logic conv_enable_out,
   output logic conv_start_out,
   output logic conv_abort_out,
   // comparator negative input steering
   output logic comp_neg_from_mux_out,
   // analog pins
   input wire logic [PINS-1:0] pin_level_in,
   output logic [PINS-1:0] pin_buf_off_out,
   output logic [PINS-1:0] pin_value_out
);

   // ***********************************************************
   // elaboration checks
   // ***********************************************************
   if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
      $error("adtr_trig_ctrl: ADDR_W must be 10..32");
   end
   if (PINS != GATE_W) begin : g_bad_pins
      $error("adtr_trig_ctrl: PINS must equal GATE_W");
   end

   // ***********************************************************
   // state
   // ***********************************************************
   logic en_q;                  // converter_enable
   logic busy_q;                // conversion in progress
   logic ate_q;                 // auto_trigger_enable
   logic done_q;                // conversion_done_flag
   logic comparator_mux_enable_q;                // comparator_mux_enable
   logic [TS_W-1:0] ts_q;       // trigger_source_select
   logic [PINS-1:0] gate_q;     // analog_pin_input_disable
   logic start_q;               // start pulse to engine
   logic abort_q;               // abort pulse to engine
   logic [31:0] prdata_q;       // read data latched in setup
   logic pslverr_q;             // error latched in setup
   logic [PINS-1:0] pin_q;      // gated port input sample

   // ***********************************************************
   // bus decode
   // ***********************************************************
   logic setup;                 // setup phase of a transfer
   logic wr;                    // write takes effect this edge
   logic hit_a;                 // address hits converter_control_a
   logic hit_b;                 // address hits converter_control_b
   logic hit_g;                 // address hits analog_pin_input_gate
   logic mapped;                // any register hit
   logic sw_start;              // software start request
   logic trig_level;            // selected trigger flag
   logic trig_edge;             // its rising edge
   logic auto_start;            // trigger-driven start
   logic [7:0] flags;           // all source flags, done flag at 0

   // upper address bits must be zero, word aligned
   assign hit_a = (paddr_in == ADDR_W'(adtr_addr(IDX_CTRL_A)));
   assign hit_b = (paddr_in == ADDR_W'(adtr_addr(IDX_CTRL_B)));
   assign hit_g = (paddr_in == ADDR_W'(adtr_addr(IDX_GATE)));
   assign mapped = hit_a || hit_b || hit_g;
   assign setup = ce_in && psel_in && !penable_in;
   // zero wait states; a frozen clock enable stalls the bus
   assign pready_out = ce_in;
   assign wr = ce_in && psel_in && penable_in && pwrite_in;
   assign prdata_out = prdata_q;
   assign pslverr_out = pslverr_q;

   // read mux and error, captured in the setup phase
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         pslverr_q <= !mapped;
         prdata_q <= 32'h0000_0000;  // unmapped reads zero
         if (hit_a) begin
            prdata_q[A_EN_BIT] <= en_q;
            prdata_q[A_START_BIT] <= busy_q;
            prdata_q[A_ATE_BIT] <= ate_q;
            prdata_q[A_DONE_BIT] <= done_q;
         end
         if (hit_b) begin
            // unassigned bits stay zero
            prdata_q[B_COMPARATOR_MUX_ENABLE_BIT] <= comparator_mux_enable_q;
            prdata_q[B_TS_LSB +: TS_W] <= ts_q;
         end
         if (hit_g) begin
            prdata_q[PINS-1:0] <= gate_q;
         end
      end
   end

   // ***********************************************************
   // control register A
   // ***********************************************************
   // software start needs the enable bit set in this same write
   assign sw_start = wr && hit_a && pwdata_in[A_START_BIT] && pwdata_in[A_EN_BIT];

   // enable and auto-trigger bits
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         en_q <= RST_CTRL_A[A_EN_BIT];
         ate_q <= RST_CTRL_A[A_ATE_BIT];
      end else if (wr && hit_a) begin
         en_q <= pwdata_in[A_EN_BIT];
         ate_q <= pwdata_in[A_ATE_BIT];
      end
   end

   // done flag: engine sets, writing one clears, set wins
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         done_q <= RST_CTRL_A[A_DONE_BIT];
      end else if (ce_in) begin
         if (conv_done_in) begin
            done_q <= 1'b1;
         end else if (wr && hit_a && pwdata_in[A_DONE_BIT]) begin
            done_q <= 1'b0;
         end
      end
   end

   // busy: set by a start, cleared by completion or switch-off
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         busy_q <= 1'b0;
      end else if (ce_in) begin
         if (wr && hit_a && !pwdata_in[A_EN_BIT]) begin
            busy_q <= 1'b0;
         end else if (sw_start || auto_start) begin
            busy_q <= 1'b1;
         end else if (conv_done_in) begin
            busy_q <= 1'b0;
         end
      end
   end

   // abort pulse when the converter is switched off mid-conversion
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         abort_q <= 1'b0;
      end else if (ce_in) begin
         abort_q <= wr && hit_a && !pwdata_in[A_EN_BIT] && busy_q;
      end
   end

   // ***********************************************************
   // control register B
   // ***********************************************************
   // only the assigned bits store
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         comparator_mux_enable_q <= RST_CTRL_B[B_COMPARATOR_MUX_ENABLE_BIT];
         ts_q <= RST_CTRL_B[B_TS_LSB +: TS_W];
      end else if (wr && hit_b) begin
         comparator_mux_enable_q <= pwdata_in[B_COMPARATOR_MUX_ENABLE_BIT];
         ts_q <= pwdata_in[B_TS_LSB +: TS_W];
      end
   end

   // comparator takes the mux only with converter off
   assign comp_neg_from_mux_out = comparator_mux_enable_q && !en_q;

   // ***********************************************************
   // auto trigger
   // ***********************************************************
   assign flags = {src_flags_in, done_q};

   adtr_trig_edge #(
      .SEL_W(TS_W)
   ) u_edge (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .ce_in(ce_in),
      .flags_in(flags),
      .sel_in(ts_q),
      .level_out(trig_level),
      .edge_out(trig_edge)
   );

   // the source field does nothing unless auto-trigger is on
   assign auto_start = trig_edge && ate_q && en_q;

   // start pulse towards the engine
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         start_q <= 1'b0;
      end else if (ce_in) begin
         start_q <= auto_start || sw_start;
      end
   end

   assign conv_start_out = start_q;
   assign conv_abort_out = abort_q;
   assign conv_enable_out = en_q;

   // ***********************************************************
   // analog pin gating
   // ***********************************************************
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         gate_q <= RST_GATE[PINS-1:0];
      end else if (wr && hit_g) begin
         gate_q <= pwdata_in[PINS-1:0];
      end
   end

   // disabled pins read zero whatever the level
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         pin_q <= '0;
      end else if (ce_in) begin
         pin_q <= pin_level_in & ~gate_q;
      end
   end

   assign pin_buf_off_out = gate_q;
   assign pin_value_out = pin_q;

   // ***********************************************************
   // assertions
   // ***********************************************************
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!resetn_in);

   sequence s_off_write;
      wr && hit_a && !pwdata_in[A_EN_BIT] && busy_q;
   endsequence

   sequence s_abort_pulse;
      conv_abort_out ##1 !conv_abort_out;
   endsequence

   chk_cmp_route: assert property (
      (wr && hit_b && pwdata_in[B_COMPARATOR_MUX_ENABLE_BIT] && !en_q) |=> comp_neg_from_mux_out)
      else $error("comparator steering wrong");
   chk_mux_when_on: assert property (
      (wr && hit_a && pwdata_in[A_EN_BIT]) |=> !comp_neg_from_mux_out)
      else $error("mux kept while converter on");
   chk_pin_default: assert property (
      (wr && hit_b && !pwdata_in[B_COMPARATOR_MUX_ENABLE_BIT]) |=> !comp_neg_from_mux_out)
      else $error("comparator not on dedicated pin");
   chk_ate_off: assert property (
      (ce_in && !ate_q && !sw_start) |=> !conv_start_out)
      else $error("start without auto-trigger");
   chk_edge_start: assert property (
      (trig_edge && ate_q && en_q && !(wr && hit_a && !pwdata_in[A_EN_BIT]))
       |=> (conv_start_out && busy_q))
      else $error("trigger edge did not start");
   chk_edge_detect: assert property (
      (ce_in && trig_level ##1 ce_in) |-> !trig_edge)
      else $error("edge on steady level");
   chk_free_switch: assert property (
      (ce_in && ts_q != TS_FREE_RUN && done_q && !conv_done_in && !(wr && hit_a)
       ##1 ts_q == TS_FREE_RUN) |-> !trig_edge)
      else $error("free running switch triggered");
   chk_abort_pulse: assert property (
      s_off_write |=> s_abort_pulse and (!busy_q && !en_q))
      else $error("switch-off did not abort");
   chk_done_set: assert property (
      (ce_in && conv_done_in) |=> done_q)
      else $error("done flag not set");
   chk_pin_gate: assert property (
      ce_in |=> ((pin_value_out & $past(gate_q)) == '0))
      else $error("disabled pin read nonzero");
   chk_reserved_zero: assert property (
      (setup && hit_b) |=> (prdata_out[7] == 1'b0 && prdata_out[5:3] == 3'b000))
      else $error("unassigned bit read nonzero");

endmodule // adtr_trig_ctrl

// file: tb/adtr_far_model.sv
// far-side model: trigger event flags and a conversion engine
`timescale 1ns/1ps
module adtr_far_model import adtr_pkg::*; (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic conv_start_in,
   input wire logic conv_abort_in,
   input wire logic [7:0] lat_in,       // conversion length, prompt or slow
   input wire logic [7:1] flag_cmd_in,  // flag levels wanted by the bench
   output logic [7:1] src_flags_out,
   output logic conv_done_out
);
   logic [7:0] cnt_q;  // cycles left in the conversion
   logic busy_q;       // conversion running
   // ***********************************************************
   // event flags, registered like real peripheral flags
   // ***********************************************************
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         src_flags_out <= '0;
      end else begin
         src_flags_out <= flag_cmd_in;
      end
   end
   // engine: runs lat_in plus one cycles, pulses done, abort drops it silently
   always_ff @(posedge core_clk_in) begin
      conv_done_out <= 1'b0;
      if (!resetn_in) begin
         busy_q <= 1'b0;
         cnt_q <= '0;
      end else if (conv_abort_in) begin
         busy_q <= 1'b0;
      end else if (conv_start_in) begin
         busy_q <= 1'b1;
         cnt_q <= lat_in;
      end else if (busy_q) begin
         if (cnt_q == 8'h00) begin
            busy_q <= 1'b0;
            conv_done_out <= 1'b1;
         end else begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule // adtr_far_model

// file: tb/tb.sv
// self-checking bench for the converter trigger block
`timescale 1ns/1ps
module tb import adtr_pkg::*; ;
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ce = 1'b1;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, done, en, start, abort, cmux;
   logic [7:1] fl = '0, flags;
   logic [7:0] lat = 8'h04;
   logic [5:0] pin_lvl = '0, buf_off, pin_val;
   int n_mismatch = 0, checked = 0, n_start = 0, n_abort = 0, cyc = 0, s0, a0;
   adtr_trig_ctrl DUT (.core_clk_in(clk), .resetn_in(rstn), .ce_in(ce), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .src_flags_in(flags),
      .conv_done_in(done), .conv_enable_out(en), .conv_start_out(start),
      .conv_abort_out(abort), .comp_neg_from_mux_out(cmux), .pin_level_in(pin_lvl),
      .pin_buf_off_out(buf_off), .pin_value_out(pin_val));
   adtr_far_model far (.core_clk_in(clk), .resetn_in(rstn), .conv_start_in(start),
      .conv_abort_in(abort), .lat_in(lat), .flag_cmd_in(fl), .src_flags_out(flags),
      .conv_done_out(done));
   // ***********************************************************
   // clock, pulse counters, hang guard
   // ***********************************************************
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (start === 1'b1) n_start++;
      if (abort === 1'b1) n_abort++;
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
   end
   // one apb transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         n_mismatch++;
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      wait_n(6);
      rstn <= 1'b1;
      // register map and reset values
      apb(0, IDX_CTRL_B, 8'h00);
      chk("ctrl_b reset", 32'h0, rd);
      apb(0, IDX_GATE, 8'h00);
      chk("gate reset", 32'h0, rd);
      apb(1, IDX_CTRL_B, 8'hFF);
      apb(0, IDX_CTRL_B, 8'h00);
      chk("ctrl_b mask", 32'h47, rd);
      chk("ctrl_b err", 32'h0, {31'h0, err});
      apb(0, 8'h10, 8'h00);
      chk("unmapped err", 32'h1, {31'h0, err});
      $display("test registers done");
      // comparator steering
      apb(1, IDX_CTRL_A, 8'h00);
      apb(1, IDX_CTRL_B, 8'h40);
      wait_n(2);
      chk("mux steer", 32'h1, {31'h0, cmux});
      apb(1, IDX_CTRL_A, 8'h80);
      wait_n(2);
      chk("mux off when enabled", 32'h0, {31'h0, cmux});
      apb(1, IDX_CTRL_A, 8'h00);
      wait_n(2);
      chk("mux back when off", 32'h1, {31'h0, cmux});
      apb(1, IDX_CTRL_B, 8'h00);
      wait_n(2);
      chk("dedicated pin", 32'h0, {31'h0, cmux});
      $display("test steering done");
      // pin gating, unused analog pins switched off
      apb(1, IDX_GATE, 8'hD5);
      pin_lvl <= 6'h3F;
      wait_n(3);
      apb(0, IDX_GATE, 8'h00);
      chk("gate mask", 32'h15, rd);
      chk("buffer off", 32'h15, {26'h0, buf_off});
      chk("gated value", 32'h2A, {26'h0, pin_val});
      $display("test gating done");
      // every source code but free running: only its own flag, only its rising edge
      apb(1, IDX_CTRL_A, 8'hA0);
      for (int c = 1; c < 8; c++) begin
         apb(1, IDX_CTRL_B, 8'(c));
         wait_n(3);
         s0 = n_start;
         fl <= ~(7'h01 << (c - 1));
         wait_n(6);
         chk("other flags", 32'(s0), 32'(n_start));
         fl <= '1;
         wait_n(12);
         chk("one start per edge", 32'(s0 + 1), 32'(n_start));
         fl <= '0;
         wait_n(3);
      end
      $display("test sources done");
      apb(0, IDX_CTRL_A, 8'h00);
      chk("done flag", 32'hB0, rd);
      s0 = n_start;
      apb(1, IDX_CTRL_B, 8'h00);
      wait_n(8);
      chk("free run switch", 32'(s0), 32'(n_start));
      // switch from a clear source onto a set one
      apb(1, IDX_CTRL_B, 8'h01);
      fl[3] <= 1'b1;
      wait_n(4);
      s0 = n_start;
      apb(1, IDX_CTRL_B, 8'h03);
      wait_n(4);
      chk("switch edge", 32'(s0 + 1), 32'(n_start));
      fl <= '0;
      wait_n(8);
      // no auto-trigger: field has no effect
      apb(1, IDX_CTRL_A, 8'h90);
      apb(1, IDX_CTRL_B, 8'h02);
      wait_n(3);
      s0 = n_start;
      fl[2] <= 1'b1;
      wait_n(6);
      chk("no auto", 32'(s0), 32'(n_start));
      fl <= '0;
      $display("test trigger done");
      // software start, then switch off mid-conversion with a slow engine
      lat <= 8'h1E;
      s0 = n_start;
      a0 = n_abort;
      apb(1, IDX_CTRL_A, 8'hC0);
      wait_n(4);
      chk("sw start", 32'(s0 + 1), 32'(n_start));
      apb(0, IDX_CTRL_A, 8'h00);
      chk("busy", 32'hC0, rd);
      apb(1, IDX_CTRL_A, 8'h00);
      wait_n(3);
      chk("abort", 32'(a0 + 1), 32'(n_abort));
      chk("enable off", 32'h0, {31'h0, en});
      apb(0, IDX_CTRL_A, 8'h00);
      chk("idle", 32'h0, rd);
      $display("test abort done");
      // clock enable low: no edge taken, pins frozen, edge seen on thaw
      apb(1, IDX_CTRL_A, 8'hA0);
      s0 = n_start;
      ce <= 1'b0;
      fl[2] <= 1'b1;
      pin_lvl <= 6'h00;
      wait_n(6);
      chk("frozen start", 32'(s0), 32'(n_start));
      chk("frozen pready", 32'h0, {31'h0, pready});
      chk("frozen pin value", 32'h2A, {26'h0, pin_val});
      ce <= 1'b1;
      wait_n(4);
      chk("start after thaw", 32'(s0 + 1), 32'(n_start));
      chk("pin value after thaw", 32'h0, {26'h0, pin_val});
      fl <= '0;
      $display("test freeze done");
      // reset in mid-run returns every register to zero
      rstn <= 1'b0;
      wait_n(2);
      rstn <= 1'b1;
      apb(0, IDX_CTRL_A, 8'h00);
      chk("ctrl_a after reset", 32'h0, rd);
      chk("enable after reset", 32'h0, {31'h0, en});
      apb(0, IDX_CTRL_B, 8'h00);
      chk("ctrl_b after reset", 32'h0, rd);
      apb(0, IDX_GATE, 8'h00);
      chk("gate after reset", 32'h0, rd);
      chk("buffer after reset", 32'h0, {26'h0, buf_off});
      $display("test reset done");
      results();
   end
endmodule // tb
